// ===== hw/psm_defs.vh
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH

// Clock and bus timing
`define PSM_CLK_PERIOD_NS 10
`define PSM_SCL_TIMEOUT_MS 25
`define PSM_RECOVER_MS 10
`define PSM_STRETCH_MAX_MS 1
`define PSM_TIMEOUT_CYCLES ((`PSM_SCL_TIMEOUT_MS * 1000000) / `PSM_CLK_PERIOD_NS)
`define PSM_TMO_W 22

// Target addresses, 7-bit form, strap value added
`define PSM_CTRL_ADDR_BASE 7'h58
`define PSM_EE_ADDR_BASE 7'h50

// Command codes
`define PSM_CMD_TEMP_INLET 8'h8d
`define PSM_CMD_TEMP_RECT 8'h8e
`define PSM_CMD_TEMP_OUTLET 8'h8f
`define PSM_CMD_TEMP_PFC 8'hea
`define PSM_CMD_EVENT_READ 8'hf1
`define PSM_CMD_FW_DATA 8'hf0

// Thermal thresholds in degrees
`define PSM_WARN_INLET 16'h003f
`define PSM_SHUT_INLET 16'h0044
`define PSM_WARN_RECT 16'h006e
`define PSM_SHUT_RECT 16'h0073
`define PSM_WARN_OUTLET 16'h0050
`define PSM_SHUT_OUTLET 16'h0055
`define PSM_WARN_PFC 16'h0060
`define PSM_SHUT_PFC 16'h0065

// Transfer limits and sizes
`define PSM_MAX_BLOCK 9'h0ff
`define PSM_EE_BYTES 256
`define PSM_EVENT_LEN 8'h05
`define PSM_IDLE_BYTE 8'hff

// Reset values
`define PSM_RST_BYTE 8'h00
`define PSM_RST_IDX 9'h000

`endif

// ===== hw/psm_sync.v
`timescale 1ns/1ns
// Two-stage synchroniser, one chain per bit
module psm_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    input wire mclk,
    input wire rst_b,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            reg stage1;
            reg stage2;
            // First stage feeds only the second stage
            always @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    stage1 <= RESET_VALUE[i];
                    stage2 <= RESET_VALUE[i];
                end else begin
                    stage1 <= asyncIn[i];
                    stage2 <= stage1;
                end
            end
            assign syncOut[i] = stage2;
        end
    endgenerate

endmodule

// ===== hw/psm_smbus_target.v
`timescale 1ns/1ns
`include "psm_defs.vh"
module psm_smbus_target #(
    parameter TIMEOUT_CYCLES = `PSM_TIMEOUT_CYCLES,
    parameter EE_BYTES = `PSM_EE_BYTES
) (
    input wire mclk,
    input wire rst_b,
    input wire sclIn,
    output wire sclOut,
    output wire sclOe,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    input wire addr_strap_high,
    input wire addr_strap_mid,
    input wire addr_strap_low,
    input wire [15:0] inlet_air_temperature,
    input wire [15:0] rectifier_switch_temperature,
    input wire [15:0] outlet_air_temperature,
    input wire [15:0] pfc_heatsink_temperature,
    input wire auxAffected,
    input wire over_voltage_protect,
    input wire over_current_protect,
    input wire inputFault,
    input wire fanFault,
    input wire otherFault,
    input wire standbyMode,
    output reg fanMax,
    output reg main_output,
    output reg standby_output,
    output reg power_good_out,
    output reg alert_out_low,
    output reg ledWarn,
    output reg ledFault,
    output reg eventStore,
    output reg [7:0] eventCause,
    output reg fwValid,
    output reg [7:0] fwByte
);

    localparam ST_IDLE = 3'd0;
    localparam ST_RECV = 3'd1;
    localparam ST_ACK = 3'd2;
    localparam ST_SEND = 3'd3;
    localparam ST_RACK = 3'd4;

    // Bus pins and straps cross into mclk; straps read high when open
    wire [4:0] syncBus;
    wire sclS;
    wire sdaS;
    wire [2:0] strap;
    psm_sync #(.WIDTH(5), .RESET_VALUE(5'h1f)) uSync (
        .mclk(mclk),
        .rst_b(rst_b),
        .asyncIn({sclIn, sdaIn, addr_strap_high, addr_strap_mid, addr_strap_low}),
        .syncOut(syncBus)
    );
    assign sclS = syncBus[4];
    assign sdaS = syncBus[3];
    assign strap = syncBus[2:0];

    // Clock is never held low, so stretching stays far below its limit
    assign sclOut = 1'b0;
    assign sclOe = 1'b0;
    assign sdaOut = 1'b0;

    reg sclPrev;
    reg sdaPrev;
    reg [2:0] state;
    reg [3:0] bitCnt;
    reg [7:0] shift;
    reg [7:0] txShift;
    reg [8:0] byteIdx;
    reg [8:0] rdIdx;
    reg tgtCtrl;
    reg readMode;
    reg ackNow;
    reg masterAck;
    reg [7:0] cmd;
    reg [7:0] ptr;
    reg sdaDrive;
    reg [`PSM_TMO_W-1:0] lowCnt;
    reg [7:0] eeMem [0:EE_BYTES-1];
    reg [39:0] eventRec;
    reg critPrev;
    reg thermShut;

    wire sclRise = sclS & ~sclPrev;
    wire sclFall = ~sclS & sclPrev;
    wire startCond = sclS & sclPrev & sdaPrev & ~sdaS;
    wire stopCond = sclS & sclPrev & ~sdaPrev & sdaS;
    wire timedOut = (lowCnt == TIMEOUT_CYCLES[`PSM_TMO_W-1:0]);
    wire [6:0] ctrlAddr = `PSM_CTRL_ADDR_BASE + {4'b0000, strap};
    wire [6:0] eeAddr = `PSM_EE_ADDR_BASE + {4'b0000, strap};
    wire byteDone = (state == ST_RECV) && sclFall && (bitCnt == 4'd8);
    wire isFwCmd = (cmd == `PSM_CMD_FW_DATA);
    wire eeWe = byteDone && (byteIdx > 9'd1) && !tgtCtrl;
    wire [8:0] byteIdxInc = (byteIdx == 9'h1ff) ? byteIdx : byteIdx + 9'd1;
    wire [8:0] rdIdxInc = (rdIdx == 9'h1ff) ? rdIdx : rdIdx + 9'd1;

    assign sdaOe = sdaDrive;

    // Byte acceptance decision for a completed byte
    reg nextAck;
    always @* begin
        nextAck = 1'b1;
        if (byteIdx == 9'd0) begin
            nextAck = (shift[7:1] == ctrlAddr) || (shift[7:1] == eeAddr);
        end else if (tgtCtrl && byteIdx > 9'd1) begin
            // Beyond 255 bytes the block is refused
            nextAck = (byteIdx <= `PSM_MAX_BLOCK) && (!isFwCmd || standbyMode);
        end
    end

    // Read data source, selected by target, command and byte index
    reg [7:0] txByte;
    always @* begin
        txByte = `PSM_IDLE_BYTE;
        if (!tgtCtrl) begin
            txByte = eeMem[ptr];
        end else if (rdIdx < `PSM_MAX_BLOCK) begin
            case (cmd)
                `PSM_CMD_TEMP_INLET: txByte = rdIdx[0] ? inlet_air_temperature[15:8] :
                    inlet_air_temperature[7:0];
                `PSM_CMD_TEMP_RECT: txByte = rdIdx[0] ? rectifier_switch_temperature[15:8] :
                    rectifier_switch_temperature[7:0];
                `PSM_CMD_TEMP_OUTLET: txByte = rdIdx[0] ? outlet_air_temperature[15:8] :
                    outlet_air_temperature[7:0];
                `PSM_CMD_TEMP_PFC: txByte = rdIdx[0] ? pfc_heatsink_temperature[15:8] :
                    pfc_heatsink_temperature[7:0];
                `PSM_CMD_EVENT_READ: begin
                    // Block read: count first, then record, any rail state
                    if (rdIdx == 9'd0) begin
                        txByte = `PSM_EVENT_LEN;
                    end else if (rdIdx <= {1'b0, `PSM_EVENT_LEN}) begin
                        txByte = eventRec[(rdIdx[2:0] - 3'd1) * 8 +: 8];
                    end
                end
                default: txByte = `PSM_IDLE_BYTE;
            endcase
        end
    end

    // SCL low watchdog; stays saturated until the clock rises
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lowCnt <= {`PSM_TMO_W{1'b0}};
        end else if (sclS) begin
            lowCnt <= {`PSM_TMO_W{1'b0}};
        end else if (!timedOut) begin
            lowCnt <= lowCnt + {{(`PSM_TMO_W-1){1'b0}}, 1'b1};
        end
    end

    // EEPROM array, host storage only
    always @(posedge mclk) begin
        if (eeWe) begin
            eeMem[ptr] <= shift;
        end
    end

    // Bit engine: sample on SCL rise, change SDA after SCL fall
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
            state <= ST_IDLE;
            bitCnt <= 4'd0;
            shift <= `PSM_RST_BYTE;
            txShift <= `PSM_RST_BYTE;
            byteIdx <= `PSM_RST_IDX;
            rdIdx <= `PSM_RST_IDX;
            tgtCtrl <= 1'b0;
            readMode <= 1'b0;
            ackNow <= 1'b0;
            masterAck <= 1'b0;
            cmd <= `PSM_RST_BYTE;
            ptr <= `PSM_RST_BYTE;
            sdaDrive <= 1'b0;
            fwValid <= 1'b0;
            fwByte <= `PSM_RST_BYTE;
        end else begin
            sclPrev <= sclS;
            sdaPrev <= sdaS;
            fwValid <= 1'b0;
            if (timedOut) begin
                // Recovery is immediate, well inside the allowed window
                state <= ST_IDLE;
                sdaDrive <= 1'b0;
            end else if (startCond) begin
                // Repeated START keeps command and pointer
                state <= ST_RECV;
                bitCnt <= 4'd0;
                byteIdx <= `PSM_RST_IDX;
                sdaDrive <= 1'b0;
            end else if (stopCond) begin
                state <= ST_IDLE;
                sdaDrive <= 1'b0;
            end else begin
                case (state)
                    ST_RECV: begin
                        if (sclRise && bitCnt != 4'd8) begin
                            shift <= {shift[6:0], sdaS};
                            bitCnt <= bitCnt + 4'd1;
                        end else if (byteDone) begin
                            ackNow <= nextAck;
                            sdaDrive <= nextAck;
                            state <= ST_ACK;
                            bitCnt <= 4'd0;
                            byteIdx <= byteIdxInc;
                            if (byteIdx == 9'd0) begin
                                tgtCtrl <= (shift[7:1] == ctrlAddr);
                                readMode <= shift[0];
                                rdIdx <= `PSM_RST_IDX;
                            end else if (byteIdx == 9'd1) begin
                                if (tgtCtrl) begin
                                    cmd <= shift;
                                end else begin
                                    ptr <= shift;
                                end
                            end else if (!tgtCtrl) begin
                                ptr <= ptr + 8'd1;
                            end else if (isFwCmd && nextAck) begin
                                fwByte <= shift;
                                fwValid <= 1'b1;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (sclFall) begin
                            if (!ackNow) begin
                                sdaDrive <= 1'b0;
                                state <= ST_IDLE;
                            end else if (readMode) begin
                                txShift <= txByte;
                                sdaDrive <= ~txByte[7];
                                rdIdx <= rdIdxInc;
                                if (!tgtCtrl) begin
                                    ptr <= ptr + 8'd1;
                                end
                                state <= ST_SEND;
                            end else begin
                                sdaDrive <= 1'b0;
                                state <= ST_RECV;
                            end
                        end
                    end
                    ST_SEND: begin
                        if (sclFall) begin
                            if (bitCnt == 4'd7) begin
                                sdaDrive <= 1'b0;
                                bitCnt <= 4'd0;
                                state <= ST_RACK;
                            end else begin
                                txShift <= {txShift[6:0], 1'b0};
                                sdaDrive <= ~txShift[6];
                                bitCnt <= bitCnt + 4'd1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (sclRise) begin
                            masterAck <= ~sdaS;
                        end else if (sclFall) begin
                            if (masterAck) begin
                                txShift <= txByte;
                                sdaDrive <= ~txByte[7];
                                rdIdx <= rdIdxInc;
                                if (!tgtCtrl) begin
                                    ptr <= ptr + 8'd1;
                                end
                                state <= ST_SEND;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        sdaDrive <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Per-sensor threshold compare
    wire [63:0] temps = {pfc_heatsink_temperature, outlet_air_temperature,
        rectifier_switch_temperature, inlet_air_temperature};
    localparam [63:0] WARN_LVL = {`PSM_WARN_PFC, `PSM_WARN_OUTLET, `PSM_WARN_RECT, `PSM_WARN_INLET};
    localparam [63:0] SHUT_LVL = {`PSM_SHUT_PFC, `PSM_SHUT_OUTLET, `PSM_SHUT_RECT, `PSM_SHUT_INLET};
    wire [3:0] warnHit;
    wire [3:0] shutHit;
    genvar s;
    generate
        for (s = 0; s < 4; s = s + 1) begin : gSensor
            assign warnHit[s] = temps[s*16 +: 16] >= WARN_LVL[s*16 +: 16];
            assign shutHit[s] = temps[s*16 +: 16] > SHUT_LVL[s*16 +: 16];
        end
    endgenerate

    wire anyWarn = |warnHit;
    wire anyShut = |shutHit;
    wire critical = over_voltage_protect | over_current_protect | inputFault |
        fanFault | otherFault | anyShut;
    wire [7:0] causeNow = {2'b00, anyShut, otherFault, fanFault, inputFault,
        over_current_protect, over_voltage_protect};

    // Protection and indication; shutdown latches until reset
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fanMax <= 1'b0;
            main_output <= 1'b1;
            standby_output <= 1'b1;
            power_good_out <= 1'b1;
            alert_out_low <= 1'b1;
            ledWarn <= 1'b0;
            ledFault <= 1'b0;
            thermShut <= 1'b0;
        end else begin
            fanMax <= anyWarn;
            if (anyShut) begin
                thermShut <= 1'b1;
            end
            if (critical) begin
                main_output <= 1'b0;
            end
            if (anyShut && auxAffected) begin
                standby_output <= 1'b0;
            end
            // All four indicators move in the same cycle
            ledWarn <= anyWarn & ~(critical | thermShut);
            ledFault <= critical | thermShut;
            power_good_out <= ~(critical | thermShut) & main_output;
            alert_out_low <= ~(anyWarn | critical | thermShut);
        end
    end

    // Event record captured on the rising edge of a critical event
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            critPrev <= 1'b0;
            eventStore <= 1'b0;
            eventCause <= `PSM_RST_BYTE;
            eventRec <= 40'h0000000000;
        end else begin
            critPrev <= critical;
            eventStore <= critical & ~critPrev;
            if (critical && !critPrev) begin
                eventCause <= causeNow;
                eventRec <= {pfc_heatsink_temperature[7:0], outlet_air_temperature[7:0],
                    rectifier_switch_temperature[7:0], inlet_air_temperature[7:0], causeNow};
            end
        end
    end

endmodule

// ===== dv/psm_smbus_target_sva.sv
`timescale 1ns/1ns
// Pin-level watch on the management target
module psm_smbus_target_sva #(
    parameter TIMEOUT_CYCLES = 2000
) (
    input wire mclk,
    input wire rst_b,
    input wire sclIn,
    input wire sclOe,
    input wire sdaIn,
    input wire sdaOe,
    input wire [15:0] inlet_air_temperature,
    input wire [15:0] rectifier_switch_temperature,
    input wire [15:0] outlet_air_temperature,
    input wire [15:0] pfc_heatsink_temperature,
    input wire auxAffected,
    input wire over_voltage_protect,
    input wire standbyMode,
    input wire fanMax,
    input wire main_output,
    input wire standby_output,
    input wire power_good_out,
    input wire alert_out_low,
    input wire ledWarn,
    input wire ledFault,
    input wire eventStore,
    input wire [7:0] eventCause,
    input wire fwValid
);
    logic warnAny;
    logic shutAny;
    logic [31:0] sclLowCnt;
    // Thresholds per sensor: warning at or above, shutdown strictly above
    assign warnAny = inlet_air_temperature >= 16'h003f || rectifier_switch_temperature >= 16'h006e
        || outlet_air_temperature >= 16'h0050 || pfc_heatsink_temperature >= 16'h0060;
    assign shutAny = inlet_air_temperature > 16'h0044 || rectifier_switch_temperature > 16'h0073
        || outlet_air_temperature > 16'h0055 || pfc_heatsink_temperature > 16'h0065;
    // Length of the present clock-low phase, raw pin
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclLowCnt <= 32'h0;
        end else if (sclIn) begin
            sclLowCnt <= 32'h0;
        end else begin
            sclLowCnt <= sclLowCnt + 32'h1;
        end
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_scl_released: assert property (!sclOe)
        else $error("target drove the clock line");
    a_warn_fan: assert property ($past(rst_b) |-> fanMax == $past(warnAny))
        else $error("fan override does not follow warning");
    a_warn_signal: assert property ($past(rst_b) && $past(warnAny)
        |-> !alert_out_low && (ledWarn || ledFault))
        else $error("warning not signalled");
    a_shut_output: assert property ($past(rst_b) && $past(shutAny)
        |-> !main_output && !power_good_out && ledFault)
        else $error("shutdown not applied");
    a_shut_latched: assert property (!main_output |=> !main_output)
        else $error("main output came back");
    a_aux_standby: assert property ($past(rst_b) && $past(shutAny && auxAffected) |-> !standby_output)
        else $error("standby output kept on");
    a_store_pulse: assert property (eventStore |=> !eventStore)
        else $error("store request longer than one cycle");
    a_ovp_record: assert property ($rose(over_voltage_protect) && main_output
        |-> ##[1:2] (eventStore && eventCause[0]))
        else $error("overvoltage not recorded");
    a_timeout_idle: assert property (sclLowCnt > TIMEOUT_CYCLES + 8 |-> !sdaOe)
        else $error("data line held after clock timeout");
    a_stop_release: assert property (sclIn && $rose(sdaIn) |-> ##[1:4] !sdaOe)
        else $error("data line held after stop");
    a_fw_gate: assert property (fwValid |-> standbyMode)
        else $error("firmware byte outside standby");
endmodule

bind psm_smbus_target psm_smbus_target_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) watch (
    .mclk(mclk), .rst_b(rst_b), .sclIn(sclIn), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOe(sdaOe),
    .inlet_air_temperature(inlet_air_temperature), .rectifier_switch_temperature(rectifier_switch_temperature),
    .outlet_air_temperature(outlet_air_temperature), .pfc_heatsink_temperature(pfc_heatsink_temperature),
    .auxAffected(auxAffected), .over_voltage_protect(over_voltage_protect), .standbyMode(standbyMode),
    .fanMax(fanMax), .main_output(main_output), .standby_output(standby_output), .power_good_out(power_good_out),
    .alert_out_low(alert_out_low), .ledWarn(ledWarn), .ledFault(ledFault), .eventStore(eventStore),
    .eventCause(eventCause), .fwValid(fwValid));

// ===== dv/psm_host_model.sv
`timescale 1ns/1ns
// Bus master: lines are only pulled low or let go to the pull-ups
module psm_host_model (
    output logic sclDrive,
    output logic sdaDrive,
    input wire logic sdaLine
);
    // Idle bus, clock stands high outside frames
    initial begin
        sclDrive = 1'b1;
        sdaDrive = 1'b1;
    end
    // One 125 ns bit cell; data moves only while the clock is low
    task automatic bitCell(input logic b, output logic s);
        sdaDrive = b;
        #31 sclDrive = 1'b1;
        #31 s = sdaLine;
        #31 sclDrive = 1'b0;
        #32;
    endtask
    // Start or repeated start, clock left low
    task automatic start;
        sdaDrive = 1'b1;
        #31 sclDrive = 1'b1;
        #31 sdaDrive = 1'b0;
        #31 sclDrive = 1'b0;
        #32;
    endtask
    // Stop, then a bus-free gap scaled far below the real one to keep runs short
    task automatic stop;
        sdaDrive = 1'b0;
        #31 sclDrive = 1'b1;
        #31 sdaDrive = 1'b1;
        #200;
    endtask
    // Byte out MSB first; low acknowledge means taken
    task automatic writeByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitCell(d[i], s);
        bitCell(1'b1, ack);
    endtask
    // Byte in MSB first, then our acknowledge or not
    task automatic readByte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bitCell(1'b1, d[i]);
        bitCell(nack, s);
    endtask
endmodule

// ===== dv/test_psu_smbus_mgmt_target.sv
`timescale 1ns/1ns
module test_psu_smbus_mgmt_target;
    localparam int TMO = 2000;
    logic mclk, rstB, sclDrive, sdaDrive, auxAffected, standbyMode, ack;
    logic [2:0] strap;
    logic [4:0] faults;
    logic [15:0] temp [4];
    logic [7:0] rd [8];
    logic [7:0] fwLast;
    logic [7:0] cmds [4] = '{8'h8d, 8'h8e, 8'h8f, 8'hea};
    logic [7:0] evExp [6] = '{8'h05, 8'h20, 8'h45, 8'h46, 8'h47, 8'h48};
    // Sensor bytes and expected fan override, one row per case
    logic [32:0] rows [9] = '{{8'h3e, 8'h6d, 8'h4f, 8'h5f, 1'b0}, {8'h3f, 8'h6d, 8'h4f, 8'h5f, 1'b1},
        {8'h44, 8'h6d, 8'h4f, 8'h5f, 1'b1}, {8'h14, 8'h6e, 8'h14, 8'h14, 1'b1}, {8'h14, 8'h73, 8'h14, 8'h14, 1'b1},
        {8'h14, 8'h14, 8'h50, 8'h14, 1'b1}, {8'h14, 8'h14, 8'h55, 8'h14, 1'b1}, {8'h14, 8'h14, 8'h14, 8'h60, 1'b1},
        {8'h14, 8'h14, 8'h14, 8'h65, 1'b1}};
    wire sclLine, sdaLine, sclOe, sdaOe, fanMax, mainOut, sbyOut, pgOut, alertB, ledWarn, ledFault, fwValid;
    wire [7:0] eventCause, fwByte;
    int errors, checks;

    // Open-drain lines with pull-ups
    assign sclLine = sclDrive & ~sclOe;
    assign sdaLine = sdaDrive & ~sdaOe;

    psm_smbus_target #(.TIMEOUT_CYCLES(TMO)) uut (.mclk(mclk), .rst_b(rstB), .sclIn(sclLine), .sclOut(),
        .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe), .addr_strap_high(strap[2]),
        .addr_strap_mid(strap[1]), .addr_strap_low(strap[0]), .inlet_air_temperature(temp[0]),
        .rectifier_switch_temperature(temp[1]), .outlet_air_temperature(temp[2]),
        .pfc_heatsink_temperature(temp[3]), .auxAffected(auxAffected), .over_voltage_protect(faults[0]),
        .over_current_protect(faults[1]), .inputFault(faults[2]), .fanFault(faults[3]), .otherFault(faults[4]),
        .standbyMode(standbyMode), .fanMax(fanMax), .main_output(mainOut), .standby_output(sbyOut),
        .power_good_out(pgOut), .alert_out_low(alertB), .ledWarn(ledWarn), .ledFault(ledFault),
        .eventStore(), .eventCause(eventCause), .fwValid(fwValid), .fwByte(fwByte));
    psm_host_model host (.sclDrive(sclDrive), .sdaDrive(sdaDrive), .sdaLine(sdaLine));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Last firmware byte handed out
    always @(posedge mclk) if (fwValid === 1'b1) fwLast <= fwByte;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic doReset;
        @(posedge mclk) #1 rstB = 1'b0;
        repeat (16) @(posedge mclk);
        #1 rstB = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // Write n bytes, then compare the last acknowledge seen
    task automatic wrSeq(input logic [7:0] ad, input logic [23:0] d, input int n, input logic expAck);
        logic a;
        host.start();
        host.writeByte(ad, a);
        for (int i = 0; i < n; i++) host.writeByte(d[23-8*i -: 8], a);
        chk(16'(a), 16'(expAck));
        host.stop();
    endtask
    // Pointer or command, repeated start, n bytes read back
    task automatic rdSeq(input logic [7:0] ad, input logic [7:0] cmd, input int n);
        logic a;
        host.start();
        host.writeByte(ad, a);
        host.writeByte(cmd, a);
        host.start();
        host.writeByte(ad | 8'h01, a);
        for (int i = 0; i < n; i++) host.readByte(i == n - 1, rd[i]);
        host.stop();
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rstB = 1'b0;
        strap = 3'h5;
        auxAffected = 1'b0;
        standbyMode = 1'b1;
        faults = 5'h00;
        fwLast = 8'h00;
        temp = '{default: 16'h0014};
        doReset();
        chk(16'({fanMax, mainOut, sbyOut, pgOut, alertB, ledWarn, ledFault, sdaOe}), 16'h0078);
        foreach (rows[i]) begin
            for (int s = 0; s < 4; s++) temp[s] = {8'h00, rows[i][32-8*s -: 8]};
            repeat (3) @(posedge mclk);
            #1 chk(16'({fanMax, alertB, ledWarn, mainOut, pgOut}),
                16'({rows[i][0], !rows[i][0], rows[i][0], 2'b11}));
        end
        wrSeq(8'haa, 24'h105a00, 2, 1'b0);
        rdSeq(8'haa, 8'h10, 1);
        chk(16'(rd[0]), 16'h005a);
        wrSeq(8'hb0, 24'h000000, 0, 1'b1);
        wrSeq(8'ha0, 24'h000000, 0, 1'b1);
        // Another strap setting moves the controller address
        @(posedge mclk) #1 strap = 3'h1;
        wrSeq(8'hb2, 24'h000000, 0, 1'b0);
        @(posedge mclk) #1 strap = 3'h5;
        for (int n = 1; n < 4; n++) wrSeq(8'hba, 24'h01a55a, n, 1'b0);
        wrSeq(8'hba, 24'hf0c300, 2, 1'b0);
        chk(16'(fwLast), 16'h00c3);
        @(posedge mclk) #1 standbyMode = 1'b0;
        wrSeq(8'hba, 24'hf03c00, 2, 1'b1);
        chk(16'(fwLast), 16'h00c3);
        // Clock held low while the target drives a read bit
        host.start();
        host.writeByte(8'haa, ack);
        host.writeByte(8'h10, ack);
        host.start();
        host.writeByte(8'hab, ack);
        #100 chk(16'(sdaOe), 16'h0001);
        #(TMO * 10 + 100) chk(16'(sdaOe), 16'h0000);
        host.stop();
        // All sensors past shutdown at once
        @(posedge mclk) #1 temp = '{16'h0145, 16'h0246, 16'h0347, 16'h0448};
        repeat (3) @(posedge mclk);
        #1 chk(16'({mainOut, pgOut, sbyOut, ledFault, eventCause}), 16'h0320);
        for (int s = 0; s < 4; s++) begin
            rdSeq(8'hba, cmds[s], 2);
            chk({rd[1], rd[0]}, temp[s]);
        end
        rdSeq(8'hba, 8'hf1, 6);
        for (int i = 0; i < 6; i++) chk(16'(rd[i]), 16'(evExp[i]));
        @(posedge mclk) #1 temp = '{default: 16'h0014};
        // Each fault source alone records its own cause
        for (int f = 0; f < 5; f++) begin
            doReset();
            faults = 5'h01 << f;
            repeat (3) @(posedge mclk);
            #1 chk(16'({eventCause, mainOut}), 16'({8'h01 << f, 1'b0}));
            faults = 5'h00;
        end
        doReset();
        auxAffected = 1'b1;
        temp[3] = 16'h0066;
        repeat (3) @(posedge mclk);
        #1 chk(16'({sbyOut, mainOut, eventCause}), 16'h0020);
        tally_and_finish();
    end
    // Hang guard, several times the expected run length
    initial begin
        #500000;
        errors++;
        tally_and_finish();
    end
endmodule
